// ==== common/pbcs_pkg.sv ====
// Constants shared by the basic control and status register block.
package pbcs_pkg;

    // ------------------------------------------------------------
    // Widths and register addresses
    // ------------------------------------------------------------
    localparam int          REG_W          = 16;
    localparam int          ADDR_W         = 5;
    localparam int          SPEED_W        = 2;
    localparam logic [4:0]  ADDR_CONTROL   = 5'h00;
    localparam logic [4:0]  ADDR_STATUS    = 5'h01;

    // ------------------------------------------------------------
    // Basic control bit positions
    // ------------------------------------------------------------
    localparam int          CTL_SPEED_LOWER = 13;
    localparam int          CTL_AN_ENABLE   = 12;
    localparam int          CTL_ISOLATE     = 10;
    localparam int          CTL_AN_RESTART  = 9;
    localparam int          CTL_DUPLEX      = 8;
    localparam int          CTL_COL_TEST    = 7;
    localparam int          CTL_SPEED_UPPER = 6;

    // ------------------------------------------------------------
    // Basic control reset values
    // ------------------------------------------------------------
    localparam logic        RST_SPEED_LOWER = 1'b0;
    localparam logic        RST_ISOLATE     = 1'b0;
    localparam logic        RST_AN_RESTART  = 1'b0;
    localparam logic        RST_COL_TEST    = 1'b0;
    localparam logic        RST_SPEED_UPPER = 1'b1;
    localparam logic        RST_AN_ENABLE   = 1'b0;
    localparam logic        RST_DUPLEX      = 1'b0;

    // ------------------------------------------------------------
    // Basic status bit positions
    // ------------------------------------------------------------
    localparam int          STS_AN_COMPLETE  = 5;
    localparam int          STS_REMOTE_FAULT = 4;
    localparam int          STS_LINK         = 2;

    // Fixed status bits: 15=0, 14..11=1, 10..9=0, 8=1, 7=0, 6=1, 3=1.
    localparam logic [15:0] STS_FIXED_VALUE  = 16'h7948;
    // Mask of the bits driven by live state.
    localparam logic [15:0] STS_LIVE_MASK    = 16'h0034;

    // ------------------------------------------------------------
    // Latched status reset values
    // ------------------------------------------------------------
    localparam logic        RST_REMOTE_FAULT = 1'b0;
    localparam logic        RST_LINK         = 1'b0;

    // ------------------------------------------------------------
    // Speed codes, upper bit first
    // ------------------------------------------------------------
    localparam logic [1:0]  SPEED_1000       = 2'h2;
    localparam logic [1:0]  SPEED_100        = 2'h1;
    localparam logic [1:0]  SPEED_10         = 2'h0;
    localparam logic [1:0]  SPEED_RESERVED   = 2'h3;

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    localparam int          RST_SYNC_STAGES  = 2;

endpackage

// ==== hdl/pbcs_latch_bit.sv ====
// Latching status bit that holds an event until the register is read.
module pbcs_latch_bit #(
    parameter logic ACTIVE    = 1'b1,
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    input  wire logic event_in,
    input  wire logic read_in,
    output logic      value_out
);

    // ------------------------------------------------------------
    // Latch
    // ------------------------------------------------------------
    // An event in the read cycle wins over the release.
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            value_out <= RESET_VAL;
        end else if (event_in) begin
            value_out <= ACTIVE;
        end else if (read_in) begin
            value_out <= ~ACTIVE;
        end
    end

endmodule

// ==== hdl/pbcs_col_test.sv ====
// Collision test generator that echoes transmit enable onto the collision output.
module pbcs_col_test (
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    input  wire logic enable_in,
    input  wire logic tx_en_in,
    output logic      col_out
);

    // ------------------------------------------------------------
    // Echo
    // ------------------------------------------------------------
    // One cycle of latency in both directions.
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            col_out <= 1'b0;
        end else begin
            col_out <= enable_in & tx_en_in;
        end
    end

endmodule

// ==== hdl/pbcs_regs.sv ====
// Basic control and status registers of the transceiver management block.
module pbcs_regs (
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    // Register access from the management frame decoder.
    input  wire logic [4:0]  mgmt_addr_in,
    input  wire logic        mgmt_wr_in,
    input  wire logic [15:0] mgmt_wdata_in,
    input  wire logic        mgmt_rd_in,
    output logic [15:0]      mgmt_rdata_out,
    output logic             mgmt_rvalid_out,
    // Configuration straps.
    input  wire logic        strap_an_enable_in,
    input  wire logic        strap_duplex_in,
    // Negotiation engine.
    input  wire logic        an_started_in,
    input  wire logic        an_complete_in,
    input  wire logic        an_duplex_in,
    input  wire logic [1:0]  an_speed_in,
    output logic             an_enable_out,
    output logic             an_restart_out,
    // Line status.
    input  wire logic        link_good_in,
    input  wire logic        far_end_fault_in,
    input  wire logic        partner_fault_in,
    // Operating mode.
    output logic             duplex_full_out,
    output logic [1:0]       speed_out,
    // MAC-side data interface.
    input  wire logic        tx_en_in,
    output logic             isolate_out,
    output logic             col_out
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [pbcs_pkg::RST_SYNC_STAGES-1:0] rst_sync_reg;
    logic                                 rst_n;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_reg <= '0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[pbcs_pkg::RST_SYNC_STAGES-2:0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[pbcs_pkg::RST_SYNC_STAGES-1];

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    // The straps load on the first clock after the reset release.
    logic strap_load_reg;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            strap_load_reg <= 1'b1;
        end else begin
            strap_load_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    logic ctl_wr;
    logic sts_rd;

    assign ctl_wr = mgmt_wr_in && (mgmt_addr_in == pbcs_pkg::ADDR_CONTROL);
    assign sts_rd = mgmt_rd_in && (mgmt_addr_in == pbcs_pkg::ADDR_STATUS);

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    logic an_enable_reg;
    logic duplex_reg;
    logic isolate_reg;
    logic col_test_reg;
    logic speed_upper_reg;
    logic speed_lower_reg;
    logic restart_reg;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            an_enable_reg <= pbcs_pkg::RST_AN_ENABLE;
        end else if (strap_load_reg) begin
            an_enable_reg <= strap_an_enable_in;
        end else if (ctl_wr) begin
            an_enable_reg <= mgmt_wdata_in[pbcs_pkg::CTL_AN_ENABLE];
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            duplex_reg <= pbcs_pkg::RST_DUPLEX;
        end else if (strap_load_reg) begin
            duplex_reg <= strap_duplex_in;
        end else if (ctl_wr) begin
            duplex_reg <= mgmt_wdata_in[pbcs_pkg::CTL_DUPLEX];
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            isolate_reg <= pbcs_pkg::RST_ISOLATE;
        end else if (ctl_wr) begin
            isolate_reg <= mgmt_wdata_in[pbcs_pkg::CTL_ISOLATE];
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            col_test_reg <= pbcs_pkg::RST_COL_TEST;
        end else if (ctl_wr) begin
            col_test_reg <= mgmt_wdata_in[pbcs_pkg::CTL_COL_TEST];
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            speed_upper_reg <= pbcs_pkg::RST_SPEED_UPPER;
            speed_lower_reg <= pbcs_pkg::RST_SPEED_LOWER;
        end else if (ctl_wr) begin
            speed_upper_reg <= mgmt_wdata_in[pbcs_pkg::CTL_SPEED_UPPER];
            speed_lower_reg <= mgmt_wdata_in[pbcs_pkg::CTL_SPEED_LOWER];
        end
    end

    // ------------------------------------------------------------
    // Negotiation restart
    // ------------------------------------------------------------
    // A write of 1 with CTL_AN_ENABLE set wins over the start acknowledge in the same cycle.
    logic restart_set;
    logic restart_next;

    assign restart_set = ctl_wr && mgmt_wdata_in[pbcs_pkg::CTL_AN_RESTART]
                         && mgmt_wdata_in[pbcs_pkg::CTL_AN_ENABLE];

    always_comb begin
        restart_next = restart_reg;
        if (restart_set) begin
            restart_next = 1'b1;
        end else if (ctl_wr && !mgmt_wdata_in[pbcs_pkg::CTL_AN_ENABLE]) begin
            restart_next = 1'b0;
        end else if (an_started_in) begin
            restart_next = 1'b0;
        end
        // A written 0 with CTL_AN_ENABLE set leaves a pending restart in place.
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            restart_reg <= pbcs_pkg::RST_AN_RESTART;
        end else begin
            restart_reg <= restart_next;
        end
    end

    // ------------------------------------------------------------
    // Operating mode
    // ------------------------------------------------------------
    logic [1:0] manual_speed;
    logic [1:0] speed_next;
    logic       duplex_next;

    assign manual_speed = {speed_upper_reg, speed_lower_reg};

    always_comb begin
        speed_next  = speed_out;
        duplex_next = duplex_full_out;
        if (an_enable_reg) begin
            duplex_next = an_duplex_in;
            if (an_speed_in != pbcs_pkg::SPEED_RESERVED) begin
                speed_next = an_speed_in;
            end
        end else begin
            duplex_next = duplex_reg;
            case (manual_speed)
                pbcs_pkg::SPEED_1000: speed_next = pbcs_pkg::SPEED_1000;
                pbcs_pkg::SPEED_100:  speed_next = pbcs_pkg::SPEED_100;
                pbcs_pkg::SPEED_10:   speed_next = pbcs_pkg::SPEED_10;
                default:              speed_next = speed_out;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            speed_out       <= {pbcs_pkg::RST_SPEED_UPPER, pbcs_pkg::RST_SPEED_LOWER};
            duplex_full_out <= pbcs_pkg::RST_DUPLEX;
        end else begin
            speed_out       <= speed_next;
            duplex_full_out <= duplex_next;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            an_enable_out  <= pbcs_pkg::RST_AN_ENABLE;
            an_restart_out <= pbcs_pkg::RST_AN_RESTART;
            isolate_out    <= pbcs_pkg::RST_ISOLATE;
        end else begin
            an_enable_out  <= an_enable_reg;
            an_restart_out <= restart_reg;
            isolate_out    <= isolate_reg;
        end
    end

    // ------------------------------------------------------------
    // Collision test
    // ------------------------------------------------------------
    // The MAC-side transmit enable is not looked at while isolated.
    logic tx_en_gated;

    assign tx_en_gated = tx_en_in & ~isolate_reg;

    pbcs_col_test u_col_test (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n),
        .enable_in (col_test_reg),
        .tx_en_in  (tx_en_gated),
        .col_out   (col_out)
    );

    // ------------------------------------------------------------
    // Latched status
    // ------------------------------------------------------------
    logic remote_fault;
    logic link_status;
    logic fault_event;

    assign fault_event = far_end_fault_in | partner_fault_in;

    pbcs_latch_bit #(
        .ACTIVE    (1'b1),
        .RESET_VAL (pbcs_pkg::RST_REMOTE_FAULT)
    ) u_remote_fault (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n),
        .event_in  (fault_event),
        .read_in   (sts_rd),
        .value_out (remote_fault)
    );

    pbcs_latch_bit #(
        .ACTIVE    (1'b0),
        .RESET_VAL (pbcs_pkg::RST_LINK)
    ) u_link_status (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n),
        .event_in  (~link_good_in),
        .read_in   (sts_rd),
        .value_out (link_status)
    );

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [15:0] ctl_value;
    logic [15:0] sts_value;
    logic [15:0] rdata_next;

    always_comb begin
        ctl_value = '0;
        ctl_value[pbcs_pkg::CTL_SPEED_LOWER] = speed_lower_reg;
        ctl_value[pbcs_pkg::CTL_AN_ENABLE]   = an_enable_reg;
        ctl_value[pbcs_pkg::CTL_ISOLATE]     = isolate_reg;
        ctl_value[pbcs_pkg::CTL_AN_RESTART]  = restart_reg;
        ctl_value[pbcs_pkg::CTL_DUPLEX]      = duplex_reg;
        ctl_value[pbcs_pkg::CTL_COL_TEST]    = col_test_reg;
        ctl_value[pbcs_pkg::CTL_SPEED_UPPER] = speed_upper_reg;
    end

    always_comb begin
        sts_value = pbcs_pkg::STS_FIXED_VALUE & ~pbcs_pkg::STS_LIVE_MASK;
        sts_value[pbcs_pkg::STS_AN_COMPLETE]  = an_complete_in;
        sts_value[pbcs_pkg::STS_REMOTE_FAULT] = remote_fault;
        sts_value[pbcs_pkg::STS_LINK]         = link_status;
    end

    always_comb begin
        case (mgmt_addr_in)
            pbcs_pkg::ADDR_CONTROL: rdata_next = ctl_value;
            pbcs_pkg::ADDR_STATUS:  rdata_next = sts_value;
            default:                rdata_next = '0;
        endcase
    end

    // The value captured here predates the clear-on-read of the same edge.
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            mgmt_rdata_out  <= '0;
            mgmt_rvalid_out <= 1'b0;
        end else begin
            mgmt_rvalid_out <= mgmt_rd_in;
            if (mgmt_rd_in) begin
                mgmt_rdata_out <= rdata_next;
            end
        end
    end

endmodule

// ==== testbench/pbcs_regs_properties.sv ====
// Concurrent checks on the ports of the basic control and status registers.
module pbcs_regs_properties (
    input wire logic        clock_in,
    input wire logic        rst_n_in,
    input wire logic [4:0]  mgmt_addr_in,
    input wire logic        mgmt_wr_in,
    input wire logic [15:0] mgmt_wdata_in,
    input wire logic        mgmt_rd_in,
    input wire logic [15:0] mgmt_rdata_out,
    input wire logic        mgmt_rvalid_out,
    input wire logic        strap_an_enable_in,
    input wire logic        strap_duplex_in,
    input wire logic        an_started_in,
    input wire logic        an_complete_in,
    input wire logic        an_duplex_in,
    input wire logic [1:0]  an_speed_in,
    input wire logic        an_enable_out,
    input wire logic        an_restart_out,
    input wire logic        link_good_in,
    input wire logic        far_end_fault_in,
    input wire logic        partner_fault_in,
    input wire logic        duplex_full_out,
    input wire logic [1:0]  speed_out,
    input wire logic        tx_en_in,
    input wire logic        isolate_out,
    input wire logic        col_out
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking dcb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence rd_sts;
        mgmt_rd_in && mgmt_addr_in == pbcs_pkg::ADDR_STATUS;
    endsequence
    sequence rd_ctl;
        mgmt_rd_in && mgmt_addr_in == pbcs_pkg::ADDR_CONTROL;
    endsequence
    sequence wr_ctl;
        mgmt_wr_in && mgmt_addr_in == pbcs_pkg::ADDR_CONTROL;
    endsequence

    read_answer_a : assert property (mgmt_rd_in |=> mgmt_rvalid_out)
        else $error("Read not answered in the next cycle.");
    fixed_status_a : assert property (
        rd_sts |=> (mgmt_rdata_out & ~pbcs_pkg::STS_LIVE_MASK) == pbcs_pkg::STS_FIXED_VALUE)
        else $error("Fixed status bits wrong.");
    ctl_reserved_a : assert property (
        rd_ctl |=> mgmt_rdata_out[5:0] == 6'h00)
        else $error("Reserved control bits not zero.");
    an_done_a : assert property (
        rd_sts |=> mgmt_rdata_out[5] == $past(an_complete_in))
        else $error("Negotiation complete bit wrong.");
    fault_latch_a : assert property (
        (far_end_fault_in || partner_fault_in) ##1 rd_sts |=> mgmt_rdata_out[4])
        else $error("Remote fault not latched.");
    link_low_a : assert property (
        !link_good_in ##1 rd_sts |=> !mgmt_rdata_out[2])
        else $error("Link failure not latched low.");
    restart_set_a : assert property (
        wr_ctl and mgmt_wdata_in[9] && mgmt_wdata_in[12] |-> ##2 an_restart_out)
        else $error("Restart request not raised.");
    restart_ignore_a : assert property (
        wr_ctl and !mgmt_wdata_in[12] |-> ##2 !an_restart_out)
        else $error("Restart honoured with negotiation off.");
    isolate_a : assert property (
        wr_ctl |-> ##2 isolate_out == $past(mgmt_wdata_in[10], 2))
        else $error("Isolate output does not follow bit 10.");
    col_release_a : assert property ($fell(tx_en_in) |=> !col_out)
        else $error("Collision not dropped after transmit enable fell.");
    col_cause_a : assert property (col_out |-> $past(tx_en_in))
        else $error("Collision without transmit enable.");
endmodule

bind pbcs_regs pbcs_regs_properties pbcs_regs_properties_inst (.*);

// ==== testbench/pbcs_mgmt_model.sv ====
// Management controller model that issues register reads and writes.
module pbcs_mgmt_model (
    input  wire logic        clock_in,
    output logic [4:0]       addr_out,
    output logic             wr_out,
    output logic [15:0]      wdata_out,
    output logic             rd_out,
    input  wire logic [15:0] rdata_in,
    input  wire logic        rvalid_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        addr_out  = 5'h1f;
        wr_out    = 1'b0;
        wdata_out = 16'h0000;
        rd_out    = 1'b0;
    end

    // Frames arrive already decoded, so preamble handling is outside this model.
    // Only control words are written, so status bit 7 is never written as 1.
    task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
        @(negedge clock_in);
        addr_out  = a;
        wdata_out = d;
        wr_out    = 1'b1;
        @(negedge clock_in);
        wr_out    = 1'b0;
        addr_out  = ~a;
        wdata_out = ~d;
    endtask

    task automatic read_reg(input logic [4:0] a, output logic [15:0] d);
        int n;
        @(negedge clock_in);
        addr_out = a;
        rd_out   = 1'b1;
        @(negedge clock_in);
        rd_out   = 1'b0;
        addr_out = ~a;
        n = 0;
        while (rvalid_in !== 1'b1 && n < 8) begin
            @(negedge clock_in);
            n++;
        end
        d = (rvalid_in === 1'b1) ? rdata_in : 16'hxxxx;
    endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking testbench of the basic control and status registers.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock_in;
    logic        rst_n_in;
    logic [4:0]  mgmt_addr_in;
    logic        mgmt_wr_in;
    logic [15:0] mgmt_wdata_in;
    logic        mgmt_rd_in;
    logic [15:0] mgmt_rdata_out;
    logic        mgmt_rvalid_out;
    logic        strap_an_enable_in;
    logic        strap_duplex_in;
    logic        an_started_in;
    logic        an_complete_in;
    logic        an_duplex_in;
    logic [1:0]  an_speed_in;
    logic        an_enable_out;
    logic        an_restart_out;
    logic        link_good_in;
    logic        far_end_fault_in;
    logic        partner_fault_in;
    logic        duplex_full_out;
    logic [1:0]  speed_out;
    logic        tx_en_in;
    logic        isolate_out;
    logic        col_out;
    int          num_errors;
    int          checked;

    pbcs_regs pbcs_regs_inst (.*);

    pbcs_mgmt_model pbcs_mgmt_model_inst (
        .clock_in  (clock_in),
        .addr_out  (mgmt_addr_in),
        .wr_out    (mgmt_wr_in),
        .wdata_out (mgmt_wdata_in),
        .rd_out    (mgmt_rd_in),
        .rdata_in  (mgmt_rdata_out),
        .rvalid_in (mgmt_rvalid_out)
    );

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    task automatic conclude();
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        pbcs_mgmt_model_inst.read_reg(a, d);
        chk(d, exp);
    endtask

    task automatic wrc(input logic [15:0] d);
        pbcs_mgmt_model_inst.write_reg(pbcs_pkg::ADDR_CONTROL, d);
        repeat (3) @(negedge clock_in);
    endtask

    task automatic do_reset();
        rst_n_in = 1'b0;
        repeat (12) @(negedge clock_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clock_in);
    endtask

    initial begin
        repeat (3000) @(posedge clock_in);
        num_errors++;
        $display("ERROR %0t: timeout", $time);
        conclude();
    end

    initial begin
        num_errors = 0;
        checked = 0;
        strap_an_enable_in = 1'b0;
        strap_duplex_in = 1'b1;
        an_started_in = 1'b0;
        an_complete_in = 1'b0;
        an_duplex_in = 1'b1;
        an_speed_in = pbcs_pkg::SPEED_100;
        link_good_in = 1'b1;
        far_end_fault_in = 1'b0;
        partner_fault_in = 1'b0;
        tx_en_in = 1'b0;
        do_reset();
        rdchk(5'h00, 16'h0140);
        rdchk(5'h05, 16'h0000);
        rdchk(5'h01, 16'h7948);
        rdchk(5'h01, 16'h794c);
        wrc(16'hffff);
        rdchk(5'h00, 16'h37c0);
        chk({15'h0, isolate_out}, 16'h0001);
        chk({15'h0, an_restart_out}, 16'h0001);
        chk({15'h0, an_enable_out}, 16'h0001);
        tx_en_in = 1'b1;
        repeat (2) @(negedge clock_in);
        chk({15'h0, col_out}, 16'h0000);
        tx_en_in = 1'b0;
        wrc(16'h1000);
        rdchk(5'h00, 16'h1200);
        chk({15'h0, isolate_out}, 16'h0000);
        an_started_in = 1'b1;
        @(negedge clock_in);
        an_started_in = 1'b0;
        rdchk(5'h00, 16'h1000);
        wrc(16'h0200);
        rdchk(5'h00, 16'h0000);
        chk({15'h0, an_restart_out}, 16'h0000);
        for (int c = 0; c < 3; c++) begin
            wrc({2'b00, c[0], 1'b0, 3'b000, c[0], 1'b0, c[1], 6'h00});
            chk({14'h0, speed_out}, c[15:0]);
            chk({15'h0, duplex_full_out}, {15'h0, c[0]});
        end
        wrc(16'h2040);
        chk({14'h0, speed_out}, 16'h0002);
        wrc(16'h3040);
        chk({14'h0, speed_out}, {14'h0, pbcs_pkg::SPEED_100});
        chk({15'h0, duplex_full_out}, 16'h0001);
        an_speed_in = pbcs_pkg::SPEED_RESERVED;
        repeat (2) @(negedge clock_in);
        chk({14'h0, speed_out}, {14'h0, pbcs_pkg::SPEED_100});
        an_speed_in = pbcs_pkg::SPEED_100;
        wrc(16'h0080);
        tx_en_in = 1'b1;
        repeat (2) @(negedge clock_in);
        chk({15'h0, col_out}, 16'h0001);
        tx_en_in = 1'b0;
        @(negedge clock_in);
        chk({15'h0, col_out}, 16'h0000);
        an_complete_in = 1'b1;
        far_end_fault_in = 1'b1;
        @(negedge clock_in);
        far_end_fault_in = 1'b0;
        rdchk(5'h01, 16'h797c);
        rdchk(5'h01, 16'h796c);
        partner_fault_in = 1'b1;
        @(negedge clock_in);
        partner_fault_in = 1'b0;
        link_good_in = 1'b0;
        rdchk(5'h01, 16'h7978);
        link_good_in = 1'b1;
        rdchk(5'h01, 16'h7968);
        rdchk(5'h01, 16'h796c);
        far_end_fault_in = 1'b1;
        rdchk(5'h01, 16'h797c);
        far_end_fault_in = 1'b0;
        rdchk(5'h01, 16'h797c);
        rdchk(5'h01, 16'h796c);
        far_end_fault_in = 1'b1;
        @(negedge clock_in);
        far_end_fault_in = 1'b0;
        do_reset();
        rdchk(5'h01, 16'h7968);
        rdchk(5'h00, 16'h0140);
        conclude();
    end
endmodule
